// ### verilog/event_mgr_irq_flags_masks.v
// Event manager interrupt flag and mask registers, three groups
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "evt_irq_defs.vh"

// Contract
// [RL1] Flag reads show set as one
// [RL2] Write one clears flag, zero keeps
// [RL3] Reserved bits read zero, ignore writes
// [RL4] Group A flag bit layout
// [RL5] Group B flags at 7430h
// [RL6] Group C flags at 7431h
// [RL7] Group A enables at 742Ch, same positions
// [RL8] Drive-fault enable resets to one
// [RL9] Group B enables at 742Dh
// [RL10] Group C enables at 742Eh
// [RL11] All other bits reset to zero
// [RL12] Event sets flag; request when enabled
// [RL13] Timer flags from counter conditions
// [RL14] Three groups, lowest bit highest priority
// [RL15] Software clears serviced flags by writing one
// [RL16] Set wins over same-cycle clear
// [RL17] Request is OR of flags and enables
module event_mgr_irq_flags_masks (
    input wire clk_in, // System clock, 10 MHz
    input wire sys_rst_in, // Async reset, active high
    input wire [15:0] addr_in, // Register word address
    input wire [15:0] wdata_in, // Write data
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    input wire drive_fault_in, // Drive protection fault event
    input wire [2:0] cmp_match_in, // Compare unit 3..1 events
    input wire [2:0] capture_in, // Capture unit 3..1 events
    input wire [15:0] timer1_cnt_in, // Timer 1 counter
    input wire [15:0] timer1_cmp_in, // Timer 1 compare value
    input wire [15:0] timer1_per_in, // Timer 1 period value
    input wire timer1_tick_in, // Timer 1 counter updated
    input wire [15:0] timer2_cnt_in, // Timer 2 counter
    input wire [15:0] timer2_cmp_in, // Timer 2 compare value
    input wire [15:0] timer2_per_in, // Timer 2 period value
    input wire timer2_tick_in, // Timer 2 counter updated
    output reg [15:0] rdata_out, // Read data, cycle after strobe
    output wire req_a_out, // Group A request
    output wire req_b_out, // Group B request
    output wire req_c_out, // Group C request
    output reg [3:0] top_a_out, // Highest pending A bit index
    output reg [1:0] top_b_out, // Highest pending B bit index
    output reg [1:0] top_c_out // Highest pending C bit index
);

    wire [15:0] flags_a;
    wire [15:0] flags_b;
    wire [15:0] flags_c;
    wire [15:0] en_a;
    wire [15:0] en_b;
    wire [15:0] en_c;
    wire [15:0] evt_a;
    wire [15:0] evt_b;
    wire [15:0] evt_c;
    wire [3:0] t1_evt;
    wire [3:0] t2_evt;
    wire [15:0] pend_a;
    wire [15:0] pend_b;
    wire [15:0] pend_c;
    reg [15:0] rdata_next;
    reg [3:0] top_a_next;
    reg [1:0] top_b_next;
    reg [1:0] top_c_next;
    integer i;

    // Timer events: period, match, under, over, only on a counter update
    assign t1_evt[0] = timer1_tick_in
                       && (timer1_cnt_in == timer1_per_in); // [RL13]
    assign t1_evt[1] = timer1_tick_in
                       && (timer1_cnt_in == timer1_cmp_in); // [RL13]
    assign t1_evt[2] = timer1_tick_in
                       && (timer1_cnt_in == `CNT_BOTTOM); // [RL13]
    assign t1_evt[3] = timer1_tick_in
                       && (timer1_cnt_in == `CNT_TOP); // [RL13]
    assign t2_evt[0] = timer2_tick_in
                       && (timer2_cnt_in == timer2_per_in); // [RL13]
    assign t2_evt[1] = timer2_tick_in
                       && (timer2_cnt_in == timer2_cmp_in); // [RL13]
    assign t2_evt[2] = timer2_tick_in
                       && (timer2_cnt_in == `CNT_BOTTOM); // [RL13]
    assign t2_evt[3] = timer2_tick_in
                       && (timer2_cnt_in == `CNT_TOP); // [RL13]

    // Group A layout: timer 1 at 10..7, compares 3..1, fault at 0
    assign evt_a = {5'h00, t1_evt[3], t1_evt[2], t1_evt[1], t1_evt[0],
                    3'h0, cmp_match_in, drive_fault_in}; // [RL4]
    assign evt_b = {12'h000, t2_evt[3], t2_evt[2], t2_evt[1],
                    t2_evt[0]}; // [RL5]
    assign evt_c = {13'h0000, capture_in}; // [RL6]

    // Three independent groups, each its own flag and enable pair
    irq_flag_group #(.IMPL_MASK(`MASK_A), .EN_RESET(`RST_A_ENABLE)) grp_a (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .event_in(evt_a),
        .flag_wr_in(wr_in && addr_in == `ADDR_A_FLAGS), // [RL4]
        .en_wr_in(wr_in && addr_in == `ADDR_A_ENABLE), // [RL7]
        .wdata_in(wdata_in),
        .flags_out(flags_a),
        .enable_out(en_a),
        .req_out(req_a_out)
    ); // [RL14]

    irq_flag_group #(.IMPL_MASK(`MASK_B), .EN_RESET(`RST_B_ENABLE)) grp_b (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .event_in(evt_b),
        .flag_wr_in(wr_in && addr_in == `ADDR_B_FLAGS), // [RL5]
        .en_wr_in(wr_in && addr_in == `ADDR_B_ENABLE), // [RL9]
        .wdata_in(wdata_in),
        .flags_out(flags_b),
        .enable_out(en_b),
        .req_out(req_b_out)
    ); // [RL14]

    irq_flag_group #(.IMPL_MASK(`MASK_C), .EN_RESET(`RST_C_ENABLE)) grp_c (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .event_in(evt_c),
        .flag_wr_in(wr_in && addr_in == `ADDR_C_FLAGS), // [RL6]
        .en_wr_in(wr_in && addr_in == `ADDR_C_ENABLE), // [RL10]
        .wdata_in(wdata_in),
        .flags_out(flags_c),
        .enable_out(en_c),
        .req_out(req_c_out)
    ); // [RL14]

    // Pending and enabled sources per group
    assign pend_a = flags_a & en_a;
    assign pend_b = flags_b & en_b;
    assign pend_c = flags_c & en_c;

    // Read mux; unmapped addresses read zero
    always @* begin
        rdata_next = 16'h0000;
        if (rd_in) begin
            case (addr_in)
                `ADDR_A_FLAGS: rdata_next = flags_a; // [RL1]
                `ADDR_B_FLAGS: rdata_next = flags_b; // [RL1]
                `ADDR_C_FLAGS: rdata_next = flags_c; // [RL1]
                `ADDR_A_ENABLE: rdata_next = en_a;
                `ADDR_B_ENABLE: rdata_next = en_b;
                `ADDR_C_ENABLE: rdata_next = en_c;
                default: rdata_next = 16'h0000; // [RL3]
            endcase
        end
    end

    // Priority: scan from high bit down so lowest set bit wins
    always @* begin
        top_a_next = 4'hF;
        top_b_next = 2'h0;
        top_c_next = 2'h0;
        for (i = 15; i >= 0; i = i - 1) begin
            if (pend_a[i]) begin
                top_a_next = i[3:0]; // [RL14]
            end
        end
        for (i = 3; i >= 0; i = i - 1) begin
            if (pend_b[i]) begin
                top_b_next = i[1:0]; // [RL14]
            end
        end
        for (i = 2; i >= 0; i = i - 1) begin
            if (pend_c[i]) begin
                top_c_next = i[1:0]; // [RL14]
            end
        end
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rdata_out <= 16'h0000;
            top_a_out <= 4'hF;
            top_b_out <= 2'h0;
            top_c_out <= 2'h0;
        end else begin
            rdata_out <= rdata_next;
            top_a_out <= top_a_next;
            top_b_out <= top_b_next;
            top_c_out <= top_c_next;
        end
    end

endmodule

// ### verilog/evt_irq_defs.vh
// Register offsets, field layouts, reset values for event interrupt flags
`ifndef EVT_IRQ_DEFS_VH
`define EVT_IRQ_DEFS_VH

// Word addresses of the six registers
`define ADDR_A_ENABLE 16'h742C
`define ADDR_B_ENABLE 16'h742D
`define ADDR_C_ENABLE 16'h742E
`define ADDR_A_FLAGS 16'h742F
`define ADDR_B_FLAGS 16'h7430
`define ADDR_C_FLAGS 16'h7431

// Implemented bit masks per group
`define MASK_A 16'h078F
`define MASK_B 16'h000F
`define MASK_C 16'h0007

// Reset values
`define RST_A_ENABLE 16'h0001
`define RST_B_ENABLE 16'h0000
`define RST_C_ENABLE 16'h0000
`define RST_FLAGS 16'h0000

// Group A field positions
`define A_DRIVE_FAULT 0
`define A_CMP1 1
`define A_CMP2 2
`define A_CMP3 3
`define A_T1_PERIOD 7
`define A_T1_MATCH 8
`define A_T1_UNDER 9
`define A_T1_OVER 10

// Timer counter limits that raise under and over flags
`define CNT_BOTTOM 16'h0000
`define CNT_TOP 16'hFFFF

`endif

// ### verilog/irq_flag_group.v
// One group of sticky event flags with write-one-to-clear and a mask
`timescale 1ns/100ps
`include "evt_irq_defs.vh"

module irq_flag_group #(
    parameter [15:0] IMPL_MASK = 16'h000F, // Implemented bits
    parameter [15:0] EN_RESET = 16'h0000 // Enable reset value
) (
    input wire clk_in, // System clock
    input wire sys_rst_in, // Async reset, high
    input wire [15:0] event_in, // One-cycle event pulses
    input wire flag_wr_in, // Write strobe to flag register
    input wire en_wr_in, // Write strobe to enable register
    input wire [15:0] wdata_in, // Write data
    output reg [15:0] flags_out, // Flag register
    output reg [15:0] enable_out, // Enable register
    output reg req_out // Group request
);

    wire [15:0] clr_bits;
    wire [15:0] flags_next;
    wire [15:0] enable_next;

    // Clear only written ones; a coincident event wins over the clear
    assign clr_bits = flag_wr_in ? (wdata_in & IMPL_MASK) : 16'h0000; // [RL2]
    assign flags_next = ((flags_out & ~clr_bits) | event_in)
                        & IMPL_MASK; // [RL16] [RL3]
    assign enable_next = en_wr_in ? (wdata_in & IMPL_MASK) : enable_out;

    // Registers; reserved bits never store, so they read as zero
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            flags_out <= `RST_FLAGS; // [RL11]
            enable_out <= EN_RESET; // [RL8] [RL11]
            req_out <= 1'b0;
        end else begin
            flags_out <= flags_next; // [RL12]
            enable_out <= enable_next; // [RL3]
            // Registered from current state: follows one cycle after change
            req_out <= |(flags_out & enable_out); // [RL17] [RL12]
        end
    end

endmodule

// ### test/irq_flags_chk_asserts.sv
// Checker for the event flag and enable register block
`timescale 1ns/100ps
module irq_flags_chk (
    input wire clk_in, // System clock
    input wire sys_rst_in, // Async reset
    input wire [15:0] addr_in, // Address
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    input wire [2:0] capture_in, // Capture events
    input wire [15:0] rdata_out, // Read data
    input wire req_a_out, // Group A request
    input wire req_b_out, // Group B request
    input wire req_c_out, // Group C request
    input wire [3:0] top_a_out, // Group A top index
    input wire [1:0] top_b_out, // Group B top index
    input wire [1:0] top_c_out // Group C top index
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // Decode checks, one cycle read latency
    a_unmapped_zero: assert property (rd_in && (addr_in < 16'h742C ||
        addr_in > 16'h7431) |=> rdata_out == 16'h0000) else $error("unmapped");
    a_idle_rdata: assert property (!rd_in |=> rdata_out == 16'h0000)
        else $error("rdata not idle");
    a_resv_a: assert property (rd_in && (addr_in == 16'h742C ||
        addr_in == 16'h742F) |=> (rdata_out & 16'hF870) == 16'h0000)
        else $error("group A reserved");
    a_resv_b: assert property (rd_in && (addr_in == 16'h742D ||
        addr_in == 16'h7430) |=> rdata_out[15:4] == 12'h000)
        else $error("group B reserved");
    a_resv_c: assert property (rd_in && (addr_in == 16'h742E ||
        addr_in == 16'h7431) |=> rdata_out[15:3] == 13'h0000)
        else $error("group C reserved");
    // Request C rises, and falls of any request, only for a cause two cycles back
    a_req_c_cause: assert property ($rose(req_c_out) |->
        $past(capture_in != 3'h0 || wr_in, 2)) else $error("req c cause");
    a_req_fall: assert property ($fell(req_a_out) || $fell(req_b_out) ||
        $fell(req_c_out) |-> $past(wr_in, 2)) else $error("req fell");
    a_top_none: assert property (!req_a_out |-> top_a_out == 4'hF)
        else $error("top a idle");
    a_top_b_idle: assert property (!req_b_out |-> top_b_out == 2'h0)
        else $error("top b idle");
    a_top_c_idle: assert property (!req_c_out |-> top_c_out == 2'h0)
        else $error("top c idle");
    cover property ($rose(req_a_out));
    cover property ($rose(req_b_out));
    cover property ($rose(req_c_out));
    cover property (rd_in && addr_in == 16'h7431);
endmodule
bind event_mgr_irq_flags_masks irq_flags_chk u_chk (.clk_in, .sys_rst_in,
    .addr_in, .wr_in, .rd_in, .capture_in, .rdata_out, .req_a_out,
    .req_b_out, .req_c_out, .top_a_out, .top_b_out, .top_c_out);

// ### test/irq_expander_model.sv
// Far-side expander model: counts request rises for groups A and C
`timescale 1ns/100ps
module irq_expander_model (
    input wire clk_in, // System clock
    input wire sys_rst_in, // Async reset
    input wire req_a_in, // Group A request
    input wire req_c_in, // Group C request
    output reg [7:0] rise_a_out, // Group A rises
    output reg [7:0] rise_c_out // Group C rises
);
    reg a_reg;
    reg c_reg;
    // Edge count stands in for acknowledge handling
    always @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            {a_reg, c_reg, rise_a_out, rise_c_out} <= 18'h00000;
        end else begin
            a_reg <= req_a_in;
            c_reg <= req_c_in;
            rise_a_out <= rise_a_out + {7'h00, req_a_in & ~a_reg};
            rise_c_out <= rise_c_out + {7'h00, req_c_in & ~c_reg};
        end
    end
endmodule

// ### test/tb_event_mgr_irq_flags_masks.sv
// Register-level bench for the event flag and enable block
`timescale 1ns/100ps
`include "evt_irq_defs.vh"
module tb_event_mgr_irq_flags_masks;
    reg clk_in = 0, sys_rst_in = 1, wr_in = 0, rd_in = 0, df = 0, tk = 0;
    reg [15:0] addr_in = 0, wdata_in = 0, cnt = 0;
    reg [2:0] cmp = 0, cap = 0;
    wire [15:0] rdata_out;
    wire ra, rb, rc;
    wire [3:0] ta;
    wire [1:0] tb, tc;
    wire [7:0] na, nc;
    reg [15:0] tv [0:3];
    integer errors = 0, compares = 0, i;
    event_mgr_irq_flags_masks dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .drive_fault_in(df), .cmp_match_in(cmp), .capture_in(cap),
        .timer1_cnt_in(cnt), .timer1_cmp_in(16'h0005),
        .timer1_per_in(16'h0009), .timer1_tick_in(tk), .timer2_cnt_in(cnt),
        .timer2_cmp_in(16'h0005), .timer2_per_in(16'h0009),
        .timer2_tick_in(tk), .rdata_out(rdata_out), .req_a_out(ra),
        .req_b_out(rb), .req_c_out(rc), .top_a_out(ta), .top_b_out(tb),
        .top_c_out(tc));
    irq_expander_model pm (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .req_a_in(ra), .req_c_in(rc), .rise_a_out(na), .rise_c_out(nc));
    initial begin
        forever #50 clk_in = ~clk_in;
    end
    task chk(input [8*8-1:0] nm, input [15:0] e, input [15:0] g);
        compares = compares + 1;
        if (g !== e) begin
            errors = errors + 1;
            $display("BAD %0s exp %h got %h", nm, e, g);
        end
    endtask
    // Write with an optional capture event in the same cycle
    task wr(input [15:0] a, input [15:0] d, input [2:0] c);
        @(posedge clk_in);
        {wr_in, addr_in, wdata_in, cap} <= {1'b1, a, d, c};
        @(posedge clk_in);
        {wr_in, cap} <= 4'h0;
    endtask
    task rd(input [15:0] a, input [15:0] e);
        @(posedge clk_in);
        {rd_in, addr_in} <= {1'b1, a};
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("rdata", e, rdata_out);
    endtask
    task stop_test;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #200000 errors = errors + 1;
        stop_test;
    end
    initial begin
        {tv[0], tv[1], tv[2], tv[3]} = {16'h0009, 16'h0005, 16'h0000, 16'hFFFF};
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 0;
        rd(`ADDR_A_ENABLE, 16'h0001);
        rd(`ADDR_B_ENABLE, 16'h0000);
        rd(`ADDR_C_ENABLE, 16'h0000);
        rd(`ADDR_A_FLAGS, 16'h0000);
        rd(16'h742B, 16'h0000);
        rd(16'h7432, 16'h0000);
        // Timer conditions: period, match, under, over
        for (i = 0; i < 4; i = i + 1) begin
            @(posedge clk_in);
            {cnt, tk} <= {tv[i], 1'b1};
            @(posedge clk_in);
            tk <= 0;
            rd(`ADDR_A_FLAGS, 16'h0080 << i);
            rd(`ADDR_B_FLAGS, 16'h0001 << i);
            wr(`ADDR_A_FLAGS, 16'hFFFF, 3'h0);
            wr(`ADDR_B_FLAGS, 16'hFFFF, 3'h0);
            rd(`ADDR_A_FLAGS, 16'h0000);
            rd(`ADDR_B_FLAGS, 16'h0000);
        end
        for (i = 0; i < 3; i = i + 1) begin
            @(posedge clk_in);
            {cmp, cap} <= {3'h1 << i, 3'h1 << i};
            @(posedge clk_in);
            {cmp, cap} <= 6'h00;
            rd(`ADDR_A_FLAGS, 16'h0002 << i);
            wr(`ADDR_C_FLAGS, 16'h0000, 3'h0);
            rd(`ADDR_C_FLAGS, 16'h0001 << i);
            wr(`ADDR_C_FLAGS, 16'h0001 << i, 3'h0);
            wr(`ADDR_A_FLAGS, 16'h0002 << i, 3'h0);
            rd(`ADDR_C_FLAGS, 16'h0000);
        end
        wr(`ADDR_A_ENABLE, 16'hFFFF, 3'h0);
        wr(`ADDR_B_ENABLE, 16'hFFFF, 3'h0);
        wr(`ADDR_C_ENABLE, 16'hFFFF, 3'h0);
        rd(`ADDR_A_ENABLE, 16'h078F);
        rd(`ADDR_B_ENABLE, 16'h000F);
        rd(`ADDR_C_ENABLE, 16'h0007);
        // Fault pulse: flag next cycle, request one later
        @(posedge clk_in);
        df <= 1;
        @(posedge clk_in);
        df <= 0;
        @(posedge clk_in);
        #1 chk("req_a", 16'h0001, {15'h0000, ra});
        chk("top_a", 16'h0000, {12'h000, ta});
        wr(`ADDR_A_ENABLE, 16'h0000, 3'h0);
        @(posedge clk_in);
        #1 chk("req_a", 16'h0000, {15'h0000, ra});
        chk("top_a", 16'h000F, {12'h000, ta});
        wr(`ADDR_C_FLAGS, 16'h0001, 3'h1);
        rd(`ADDR_C_FLAGS, 16'h0001);
        chk("req_c", 16'h0001, {15'h0000, rc});
        chk("rises_a", 16'h0001, {8'h00, na});
        chk("rises_c", 16'h0001, {8'h00, nc});
        // Two captures at once, clear of the first: lowest pending wins
        wr(`ADDR_C_FLAGS, 16'h0001, 3'h6);
        rd(`ADDR_C_FLAGS, 16'h0006);
        chk("top_c", 16'h0001, {14'h0000, tc});
        // Timer 2 match with group B enabled: request, index, clear
        @(posedge clk_in);
        {cnt, tk} <= {16'h0005, 1'b1};
        @(posedge clk_in);
        tk <= 1'b0;
        @(posedge clk_in);
        #1 chk("req_b", 16'h0001, {15'h0000, rb});
        chk("top_b", 16'h0001, {14'h0000, tb});
        wr(`ADDR_B_FLAGS, 16'h0002, 3'h0);
        @(posedge clk_in);
        #1 chk("req_b", 16'h0000, {15'h0000, rb});
        stop_test;
    end
endmodule
